// ==== src/mff_framer.sv ====
// Purpose: master request framer for write-multiple and read-holding commands
// Assumes: local memory read is combinational on mem_rd_addr_o; rx bytes from same-clock logic
// Notes: no checksum, no response timeout; other function codes are refused with err_o
// Behaviour
// RQ1: Float option off: each register is one 16-bit word, threshold ignored.
// RQ2: Write with float off: byte count is two per register, count 2 gives 4.
// RQ3: Write frame: slave, 0x10, start address high first, count, byte count, data.
// RQ4: Read requests ignore float option and float threshold.
// RQ5: Read requests point count registers; replies stored from local buffer offset.
// RQ6: Read frame: slave, 0x03, start address high first, register count.
// RQ7: Float-addressing slave answers two-register read with 8 bytes, others with 4.
// RQ8: Slave may size write data from byte count or from a fixed offset.
// RQ9: Configured remote start address goes into the frame unchanged.
// RQ10: Float on and address at or above threshold doubles write byte count.
// RQ11: Data bytes and words reordered by the command's swap code.
`timescale 1ns/10ps
module mff_framer (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Command entry
	input wire logic cmd_valid_i,
	input wire mff_pkg::mff_cmd_s cmd_i,
	output logic cmd_ready_o,
	// Transmit byte stream
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	input wire logic tx_ready_i,
	// Receive byte stream
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	// Local data memory
	output logic [15:0] mem_rd_addr_o,
	input wire logic [15:0] mem_rd_data_i,
	output mff_pkg::mff_wr_s mem_wr_o,
	// Status
	output logic busy_o,
	output logic done_o,
	output logic err_o
);
	import mff_pkg::*;

	mff_state_e state_reg, state_next;
	mff_cmd_s cmd_reg, cmd_next;
	mff_wr_s wr_reg, wr_next;
	logic [31:0] out_reg, out_next, acc_reg, acc_next;
	logic [2:0] out_n_reg, out_n_next;
	logic hdr_reg, hdr_next, last_reg, last_next, done_reg, done_next, err_reg, err_next;
	logic [16:0] words_reg, words_next;
	logic [15:0] addr_reg, addr_next;
	logic [1:0] rx_idx_reg, rx_idx_next, rbytes_reg, rbytes_next;
	logic [7:0] rx_left_reg, rx_left_next;
	logic [31:0] sw_in, sw_out;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire is_write = cmd_reg.func == FUNC_WRITE;
	wire is_read = cmd_reg.func == FUNC_READ;
	wire accept = state_reg == S_IDLE && cmd_valid_i;
	wire cmd_ok = cmd_i.func == FUNC_WRITE || cmd_i.func == FUNC_READ;
	wire tx_fire = tx_valid_o && tx_ready_i;
	wire rx_fire = rx_valid_i && (state_reg == S_RX_HDR || state_reg == S_RX_DATA);
	// Count field is the point count for both codes; byte count only on writes
	wire [31:0] chunk1 = {cmd_reg.point_count, byte_count(cmd_reg), 8'h00}; // RQ2 RQ4 RQ10
	wire [2:0] chunk1_len = is_write ? CHUNK1_WR_LEN : CHUNK1_RD_LEN; // RQ3 RQ6
	wire rx_pair = state_reg == S_RX_DATA && rbytes_reg == 2'h3;
	wire pair_full = state_reg == S_RD_B || rx_pair;
	wire rx_single = state_reg == S_RX_DATA && rbytes_reg == 2'h1 && rx_left_reg == 8'h01;

	assign acc_next = {acc_reg[23:0], rx_data_i};
	// A lone word has no partner, so only its bytes may swap
	assign sw_in = state_reg == S_RD_B ? {out_reg[31:16], mem_rd_data_i} :
		state_reg == S_RD_A ? {mem_rd_data_i, 16'h0000} :
		rx_pair ? acc_next : {acc_next[15:0], 16'h0000};
	wire [1:0] sw_code = pair_full ? cmd_reg.swap_code : cmd_reg.swap_code & SWAP_BYTE;

	mff_swap u_swap (
		.val_i(sw_in),
		.code_i(sw_code),
		.val_o(sw_out)
	); // RQ11

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		out_next = out_reg;
		out_n_next = out_n_reg;
		hdr_next = hdr_reg;
		last_next = last_reg;
		words_next = words_reg;
		addr_next = addr_reg;
		rx_idx_next = rx_idx_reg;
		rx_left_next = rx_left_reg;
		rbytes_next = rbytes_reg;
		wr_next = '0;
		done_next = 1'b0;
		err_next = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (cmd_valid_i) begin
					cmd_next = cmd_i;
					addr_next = cmd_i.local_buffer_offset; // RQ5
					words_next = data_words(cmd_i); // RQ1 RQ10
					last_next = 1'b0;
					if (cmd_ok) begin
						out_next = {cmd_i.slave_addr, cmd_i.func, cmd_i.remote_addr}; // RQ3 RQ6 RQ9
						out_n_next = CHUNK0_LEN;
						hdr_next = 1'b1;
						state_next = S_SEND;
					end else begin
						err_next = 1'b1;
					end
				end
			end
			S_SEND: begin
				if (tx_fire) begin
					out_next = {out_reg[23:0], 8'h00};
					out_n_next = out_n_reg - 3'h1;
					if (out_n_reg == 3'h1) begin
						if (hdr_reg) begin
							out_next = chunk1;
							out_n_next = chunk1_len;
							hdr_next = 1'b0;
							last_next = is_read || words_reg == 17'h0;
						end else if (!last_reg) begin
							state_next = S_RD_A;
						end else if (is_read) begin
							rx_idx_next = RX_IDX_ADDR;
							state_next = S_RX_HDR;
						end else begin
							done_next = 1'b1;
							state_next = S_IDLE;
						end
					end
				end
			end
			S_RD_A: begin
				addr_next = addr_reg + 16'h0001;
				words_next = words_reg - 17'h1;
				if (words_reg > 17'h1) begin
					out_next = {mem_rd_data_i, 16'h0000};
					state_next = S_RD_B;
				end else begin
					out_next = sw_out;
					out_n_next = 3'h2;
					last_next = 1'b1;
					state_next = S_SEND;
				end
			end
			S_RD_B: begin
				addr_next = addr_reg + 16'h0001;
				words_next = words_reg - 17'h1;
				out_next = sw_out;
				out_n_next = 3'h4;
				last_next = words_reg == 17'h1;
				state_next = S_SEND;
			end
			S_RX_HDR: begin
				if (rx_valid_i) begin
					rx_idx_next = rx_idx_reg + 2'h1;
					// A mismatched function byte also catches exception replies
					if ((rx_idx_reg == RX_IDX_ADDR && rx_data_i != cmd_reg.slave_addr) ||
						(rx_idx_reg == RX_IDX_FUNC && rx_data_i != cmd_reg.func)) begin
						err_next = 1'b1;
						state_next = S_IDLE;
					end else if (rx_idx_reg == RX_IDX_COUNT) begin
						rx_left_next = rx_data_i; // RQ7
						rbytes_next = 2'h0;
						if (rx_data_i == 8'h00) begin
							done_next = 1'b1;
							state_next = S_IDLE;
						end else begin
							state_next = S_RX_DATA;
						end
					end
				end
			end
			S_RX_DATA: begin
				if (rx_valid_i) begin
					rbytes_next = rbytes_reg + 2'h1;
					rx_left_next = rx_left_reg - 8'h01;
					if (rx_pair) begin
						wr_next = '{en: 1'b1, pair: 1'b1, addr: addr_reg, data: sw_out}; // RQ5
						addr_next = addr_reg + 16'h0002;
					end else if (rx_single) begin
						wr_next = '{en: 1'b1, pair: 1'b0, addr: addr_reg, data: sw_out};
						addr_next = addr_reg + 16'h0001;
					end
					if (rx_left_reg == 8'h01) begin
						done_next = 1'b1;
						state_next = S_IDLE;
					end
				end
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= S_IDLE;
			cmd_reg <= '0;
			out_reg <= 32'h0;
			out_n_reg <= 3'h0;
			hdr_reg <= 1'b0;
			last_reg <= 1'b0;
			words_reg <= 17'h0;
			addr_reg <= 16'h0;
			rx_idx_reg <= 2'h0;
			rx_left_reg <= 8'h00;
			rbytes_reg <= 2'h0;
			acc_reg <= 32'h0;
			wr_reg <= '0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			out_reg <= out_next;
			out_n_reg <= out_n_next;
			hdr_reg <= hdr_next;
			last_reg <= last_next;
			words_reg <= words_next;
			addr_reg <= addr_next;
			rx_idx_reg <= rx_idx_next;
			rx_left_reg <= rx_left_next;
			rbytes_reg <= rbytes_next;
			acc_reg <= rx_fire ? acc_next : acc_reg;
			wr_reg <= wr_next;
			done_reg <= done_next;
			err_reg <= err_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign cmd_ready_o = state_reg == S_IDLE;
	assign busy_o = state_reg != S_IDLE;
	assign tx_valid_o = state_reg == S_SEND;
	assign tx_data_o = out_reg[31:24];
	assign tx_last_o = tx_valid_o && out_n_reg == 3'h1 && last_reg && !hdr_reg;
	assign mem_rd_addr_o = addr_reg;
	assign mem_wr_o = wr_reg;
	assign done_o = done_reg;
	assign err_o = err_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [17:0] tx_pos_reg;
	logic first_wr_reg;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_pos_reg <= 18'h0;
			first_wr_reg <= 1'b0;
		end else begin
			tx_pos_reg <= accept ? 18'h0 : tx_fire ? tx_pos_reg + 18'h1 : tx_pos_reg;
			first_wr_reg <= accept ? 1'b1 : wr_reg.en ? 1'b0 : first_wr_reg;
		end
	end
	wire [17:0] wr_last_pos = WR_HDR_LEN + {1'b0, cmd_reg.point_count, 1'b0} - 18'h1;
	wire float_hit = cmd_reg.float_en && cmd_reg.remote_addr >= cmd_reg.float_threshold;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_slave_first: assert property (tx_fire && tx_pos_reg == 18'h0 |-> // RQ3
		tx_data_o == cmd_reg.slave_addr) else $error("slave address not first");
	chk_write_func: assert property (tx_fire && tx_pos_reg == 18'h1 && is_write |-> // RQ3
		tx_data_o == FUNC_WRITE) else $error("write function code wrong");
	chk_start_addr: assert property (tx_fire |-> // RQ9
		(tx_pos_reg != 18'h2 || tx_data_o == cmd_reg.remote_addr[15:8]) &&
		(tx_pos_reg != 18'h3 || tx_data_o == cmd_reg.remote_addr[7:0]))
		else $error("start address altered");
	chk_plain_bcount: assert property (tx_fire && tx_pos_reg == 18'h6 && is_write && // RQ2
		!cmd_reg.float_en |-> tx_data_o == {cmd_reg.point_count[6:0], 1'b0})
		else $error("byte count not two per register");
	chk_float_bcount: assert property (tx_fire && tx_pos_reg == 18'h6 && is_write && // RQ10
		float_hit |-> tx_data_o == {cmd_reg.point_count[5:0], 2'b00})
		else $error("float byte count not doubled");
	chk_plain_length: assert property (tx_fire && tx_last_o && is_write && // RQ1
		!cmd_reg.float_en |-> tx_pos_reg == wr_last_pos) else $error("write frame length wrong");
	chk_read_func: assert property (tx_fire && tx_pos_reg == 18'h1 && is_read |-> // RQ6
		tx_data_o == FUNC_READ) else $error("read function code wrong");
	chk_read_count: assert property (tx_fire && is_read && tx_pos_reg == RD_FRAME_LEN - 18'h1 |-> // RQ4
		tx_data_o == cmd_reg.point_count[7:0] && tx_last_o ##1 state_reg == S_RX_HDR)
		else $error("read request count or length wrong");
	chk_first_store: assert property (mem_wr_o.en && first_wr_reg |-> // RQ5
		mem_wr_o.addr == cmd_reg.local_buffer_offset) else $error("store not at buffer offset");
	chk_swap_none: assert property (mem_wr_o.en && mem_wr_o.pair && cmd_reg.swap_code == 2'h0 |-> // RQ11
		mem_wr_o.data[7:0] == $past(rx_data_i)) else $error("unswapped store reordered");

	cov_write_done: cover property (tx_fire && tx_last_o && is_write ##1 done_o);
	cov_float_write: cover property (tx_fire && tx_pos_reg == 18'h6 && is_write && float_hit);
	cov_read_store: cover property (mem_wr_o.en && mem_wr_o.pair ##[1:8] done_o);
	cov_refused: cover property (err_o);

endmodule // mff_framer

// ==== src/mff_pkg.sv ====
// Purpose: shared types and constants for the serial master request framer
// Assumes: one 50 MHz core clock; no checksum or line timing inside the framer
// Notes: swap code bit 0 swaps words of a pair, bit 1 swaps bytes of each word
package mff_pkg;

	// ------------------------------------------------------------
	// Function codes and field encodings
	// ------------------------------------------------------------
	localparam logic [7:0] FUNC_READ = 8'h03;
	localparam logic [7:0] FUNC_WRITE = 8'h10;
	localparam logic [1:0] SWAP_WORD = 2'h1;
	localparam logic [1:0] SWAP_BYTE = 2'h2;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam logic [2:0] CHUNK0_LEN = 3'h4;
	localparam logic [2:0] CHUNK1_WR_LEN = 3'h3;
	localparam logic [2:0] CHUNK1_RD_LEN = 3'h2;
	localparam logic [17:0] WR_HDR_LEN = 18'h00007;
	localparam logic [17:0] RD_FRAME_LEN = 18'h00006;
	localparam logic [1:0] RX_IDX_ADDR = 2'h0;
	localparam logic [1:0] RX_IDX_FUNC = 2'h1;
	localparam logic [1:0] RX_IDX_COUNT = 2'h2;

	typedef enum logic [2:0] {
		S_IDLE, S_SEND, S_RD_A, S_RD_B, S_RX_HDR, S_RX_DATA
	} mff_state_e;

	// One command-table entry
	typedef struct packed {
		logic [7:0] slave_addr;
		logic [7:0] func;
		logic [15:0] remote_addr;
		logic [15:0] point_count;
		logic [15:0] local_buffer_offset;
		logic float_en;
		logic [15:0] float_threshold;
		logic [1:0] swap_code;
	} mff_cmd_s;

	// Local memory write; single words sit in data[31:16]
	typedef struct packed {
		logic en;
		logic pair;
		logic [15:0] addr;
		logic [31:0] data;
	} mff_wr_s;

	// Data words of a write: doubled only for float writes at or above threshold
	function automatic logic [16:0] data_words(input mff_cmd_s c);
		if (c.func == FUNC_WRITE && c.float_en && c.remote_addr >= c.float_threshold) begin
			return {c.point_count, 1'b0};
		end
		return {1'b0, c.point_count};
	endfunction

	function automatic logic [7:0] byte_count(input mff_cmd_s c);
		logic [16:0] w;
		w = data_words(c);
		return {w[6:0], 1'b0};
	endfunction

endpackage

// ==== src/mff_swap.sv ====
// Purpose: byte and word reordering of one 32-bit data value
// Assumes: code bit 0 swaps the words, bit 1 swaps bytes within each word
// Notes: purely combinational
`timescale 1ns/10ps
module mff_swap (
	// Value in
	input wire logic [31:0] val_i,
	input wire logic [1:0] code_i,
	// Value out
	output logic [31:0] val_o
);
	import mff_pkg::*;

	wire [31:0] word_sw = (code_i & SWAP_WORD) != 2'h0 ? {val_i[15:0], val_i[31:16]} : val_i;

	assign val_o = (code_i & SWAP_BYTE) != 2'h0 ?
		{word_sw[23:16], word_sw[31:24], word_sw[7:0], word_sw[15:8]} : word_sw;

endmodule // mff_swap

// ==== tb/mff_slave_model.sv ====
// Purpose: remote serial slave answering the framer's read requests
// Assumes: same clock as the framer; reply starts one cycle after the last request byte
// Notes: slow_i halves ready and reply rate; float_addr_i picks 4 bytes per register
`timescale 1ns/10ps
module mff_slave_model (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Mode
	input wire logic slow_i,
	input wire logic float_addr_i,
	// Request stream
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_last_i,
	output logic tx_ready_o,
	// Reply stream
	output logic rx_valid_o,
	output logic [7:0] rx_data_o
);
	logic [7:0] hdr [0:5];
	logic [7:0] cnt;
	logic tick;
	int n;
	int rem;
	int idx;
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_ready_o <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_data_o <= 8'h00;
			tick <= 1'b0;
			n = 0;
			rem = 0;
			idx = 0;
		end else begin
			tick <= ~tick;
			tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
			rx_valid_o <= 1'b0;
			// Idle line keeps moving so a stale byte is never mistaken for data
			rx_data_o <= ~rx_data_o;
			if (tx_valid_i && tx_ready_o) begin
				// Write data length taken from the frame end, not the count
				if (n < 6) hdr[n] = tx_data_i;
				n = n + 1;
				if (tx_last_i) begin
					n = 0;
					if (hdr[1] == 8'h03) begin
						cnt = float_addr_i ? {hdr[5][5:0], 2'h0} : {hdr[5][6:0], 1'h0};
						rem = cnt + 3;
						idx = 0;
					end
				end
			end else if (rem > 0 && (!slow_i || tick)) begin
				rx_valid_o <= 1'b1;
				rx_data_o <= idx == 0 ? hdr[0] : idx == 1 ? 8'h03 : idx == 2 ? cnt : 8'h9D + idx;
				idx = idx + 1;
				rem = rem - 1;
			end
		end
	end
endmodule // mff_slave_model

// ==== tb/modbus_master_float_framer_tb.sv ====
// Purpose: self-checking bench for the request framer
// Assumes: local memory modelled here, read combinationally
// Notes: reply data bytes from the slave model run A0, A1, ...
`timescale 1ns/10ps
module modbus_master_float_framer_tb;
	import mff_pkg::*;
	logic core_clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, tx_valid_o, tx_last_o, tx_ready_i;
	logic rx_valid_i, busy_o, done_o, err_o, slow, fpt, done_seen, err_seen;
	logic [7:0] tx_data_o, rx_data_i;
	logic [15:0] mem_rd_addr_o;
	logic [15:0] mem [0:31];
	mff_cmd_s cmd_i;
	mff_wr_s mem_wr_o;
	logic [7:0] txq [$];
	int err_total, checks_done, cyc, tnum, last_at;
	mff_framer u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
		.tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .rx_valid_i(rx_valid_i),
		.rx_data_i(rx_data_i), .mem_rd_addr_o(mem_rd_addr_o),
		.mem_rd_data_i(mem[mem_rd_addr_o[4:0]]), .mem_wr_o(mem_wr_o), .busy_o(busy_o),
		.done_o(done_o), .err_o(err_o));
	mff_slave_model u_slave (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
		.float_addr_i(fpt), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
		.tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i));
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
			txq.push_back(tx_data_o);
			if (tx_last_o === 1'b1) last_at = txq.size();
		end
		if (mem_wr_o.en === 1'b1) begin
			mem[mem_wr_o.addr[4:0]] <= mem_wr_o.data[31:16];
			if (mem_wr_o.pair) mem[mem_wr_o.addr[4:0] + 5'h01] <= mem_wr_o.data[15:0];
		end
		cyc <= cyc + 1;
		// Generous against the whole run of all commands, slow mode included
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end
	// Wide enough for four memory words at once
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk_frame(input logic [7:0] e [$]);
		check(txq.size(), e.size());
		check(last_at, e.size());
		foreach (e[i]) check({24'h0, txq[i]}, {24'h0, e[i]});
		txq.delete();
		last_at = 0;
	endtask
	// Offer one command, then wait for its end flag
	task automatic run_cmd(input logic [7:0] f, input logic [15:0] a, input logic [15:0] c,
		input logic [15:0] off, input logic fe, input logic [15:0] th, input logic [1:0] sw);
		@(posedge core_clk_i);
		cmd_i <= '{8'h01, f, a, c, off, fe, th, sw};
		cmd_valid_i <= 1'b1;
		@(posedge core_clk_i);
		cmd_valid_i <= 1'b0;
		done_seen = 1'b0;
		err_seen = 1'b0;
		repeat (400) begin
			@(negedge core_clk_i);
			done_seen = done_o;
			err_seen = err_o;
			if (done_seen === 1'b1 || err_seen === 1'b1) break;
		end
		repeat (3) @(posedge core_clk_i);
		tnum++;
		$display("test %0d finished", tnum);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		err_total = 0;
		checks_done = 0;
		tnum = 0;
		cyc = 0;
		last_at = 0;
		rst_n_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_i = '0;
		slow = 1'b0;
		fpt = 1'b0;
		foreach (mem[i]) mem[i] = 16'h0000;
		mem[4] = 16'h1234;
		mem[5] = 16'h5678;
		mem[6] = 16'h9ABC;
		mem[7] = 16'hDEF0;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		run_cmd(FUNC_WRITE, 16'h1BBC, 16'h0002, 16'h0004, 1'b0, 16'h1B58, 2'h0);
		check(done_seen, 1'b1);
		chk_frame('{8'h01, 8'h10, 8'h1B, 8'hBC, 8'h00, 8'h02, 8'h04,
			8'h12, 8'h34, 8'h56, 8'h78});
		slow <= 1'b1;
		run_cmd(FUNC_WRITE, 16'h1BBC, 16'h0002, 16'h0004, 1'b1, 16'h1B58, 2'h0);
		chk_frame('{8'h01, 8'h10, 8'h1B, 8'hBC, 8'h00, 8'h02, 8'h08, 8'h12, 8'h34,
			8'h56, 8'h78, 8'h9A, 8'hBC, 8'hDE, 8'hF0});
		slow <= 1'b0;
		// Threshold just above the address: no doubling
		run_cmd(FUNC_WRITE, 16'h1BBC, 16'h0002, 16'h0004, 1'b1, 16'h1BBD, 2'h3);
		chk_frame('{8'h01, 8'h10, 8'h1B, 8'hBC, 8'h00, 8'h02, 8'h04,
			8'h78, 8'h56, 8'h34, 8'h12});
		// Odd count: last word has no partner, only its bytes swap
		run_cmd(FUNC_WRITE, 16'h1BBC, 16'h0003, 16'h0004, 1'b0, 16'h0000, 2'h3);
		chk_frame('{8'h01, 8'h10, 8'h1B, 8'hBC, 8'h00, 8'h03, 8'h06, 8'h78, 8'h56,
			8'h34, 8'h12, 8'hBC, 8'h9A});
		run_cmd(FUNC_READ, 16'h17D4, 16'h0002, 16'h0010, 1'b1, 16'h0000, 2'h0);
		check(done_seen, 1'b1);
		chk_frame('{8'h01, 8'h03, 8'h17, 8'hD4, 8'h00, 8'h02});
		check({mem[16], mem[17], mem[18]}, {16'hA0A1, 16'hA2A3, 16'h0000});
		fpt <= 1'b1;
		slow <= 1'b1;
		run_cmd(FUNC_READ, 16'h17D4, 16'h0002, 16'h0014, 1'b0, 16'h0000, 2'h0);
		chk_frame('{8'h01, 8'h03, 8'h17, 8'hD4, 8'h00, 8'h02});
		check({mem[20], mem[21], mem[22], mem[23]},
			{16'hA0A1, 16'hA2A3, 16'hA4A5, 16'hA6A7});
		run_cmd(8'h06, 16'h1BBC, 16'h0001, 16'h0004, 1'b0, 16'h0000, 2'h0);
		check(err_seen, 1'b1);
		check(txq.size(), 0);
		// Reset in mid-frame: block drops back to idle and serves again
		@(posedge core_clk_i);
		cmd_i <= '{8'h01, FUNC_WRITE, 16'h1BBC, 16'h0002, 16'h0004, 1'b0, 16'h0000, 2'h0};
		cmd_valid_i <= 1'b1;
		@(posedge core_clk_i);
		cmd_valid_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		check({cmd_ready_o, busy_o}, 2'b01);
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		@(negedge core_clk_i);
		check({cmd_ready_o, busy_o, tx_valid_o}, 3'b100);
		@(posedge core_clk_i);
		rst_n_i <= 1'b1;
		fpt <= 1'b0;
		txq.delete();
		last_at = 0;
		run_cmd(FUNC_READ, 16'h17D4, 16'h0003, 16'h0018, 1'b0, 16'h0000, 2'h3);
		check(done_seen, 1'b1);
		chk_frame('{8'h01, 8'h03, 8'h17, 8'hD4, 8'h00, 8'h03});
		check({mem[24], mem[25], mem[26]}, {16'hA3A2, 16'hA1A0, 16'hA5A4});
		test_done();
	end
endmodule // modbus_master_float_framer_tb
